/* include/ebi_pkg.sv */
// Shared constants and types of the external bus interface
package ebi_pkg;
	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;
	localparam int WAIT_W = 3;
	localparam logic [1:0] SPACE_PROG = 2'h0;
	localparam logic [1:0] SPACE_DATA = 2'h1;
	localparam logic [1:0] SPACE_IO   = 2'h2;
	// Start of the top 16K words of the first 64K of program space
	localparam logic [15:0] ROM_BASE = 16'hC000;
	localparam logic [WAIT_W-1:0] READY_MIN_WAITS = 3'h2;
	localparam logic GRANT_ACK_RST_N = 1'b1;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACCESS,
		ST_HOLD
	} ebi_state_t;
endpackage

/* verilog/ebi_wait_ctr.sv */
// Down counter for the software wait states of one access
`timescale 1ns/1ps
`default_nettype none
module ebi_wait_ctr #(
	parameter int W = 3
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              cnt_zero
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	assign cnt_zero = (cnt_reg == '0);
	assign cnt_next = load ? load_val : (cnt_zero ? cnt_reg : cnt_reg - W'(1));

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (ce) begin
			cnt_reg <= cnt_next;
		end
	end
endmodule
`default_nettype wire

/* verilog/ebi_top.sv */
// External bus controller: space selects, strobes, ready wait, hold, ROM map
// Notes on behaviour
// - ROM map select low at reset maps the internal ROM into the top 16K words of the first 64K of program space.
// - ROM map select high at reset removes the ROM so those addresses go external.
// - The select is caught only in reset and a mode write can later override it.
// - Space selects idle high and only the one for the accessed space goes low.
// - The active space select spans exactly the time the address is valid.
// - The memory strobe is low only for external program or data accesses.
// - The I/O strobe is low only for external I/O accesses.
// - The direction output stays high and goes low only during a write.
// - The far device holds ready low while busy and each low sample adds one cycle.
// - Ready is looked at only when two or more software waits are programmed.
// - Ready is not sampled before all software waits of the access are done.
// - A master requests the bus by hold and after the acknowledge all lines but the acknowledge float.
// - In hold the selects, both strobes and the direction output float.
// - Float control low tri-states the selects, strobes and direction at any time.
// - The hold acknowledge shows the floated hold state and is high in reset.
`timescale 1ns/1ps
`default_nettype none
module ebi_top #(
	parameter int ADDR_W = ebi_pkg::ADDR_W,
	parameter int DATA_W = ebi_pkg::DATA_W
) (
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	input  wire logic                      ce,
	input  wire logic                      req_valid,
	output logic                           req_ready,
	input  wire logic [1:0]                req_space,
	input  wire logic                      req_write,
	input  wire logic [ADDR_W-1:0]         req_addr,
	input  wire logic [DATA_W-1:0]         req_wdata,
	input  wire logic [ebi_pkg::WAIT_W-1:0] req_waits,
	output logic                           resp_valid,
	output logic                           resp_internal,
	output logic [DATA_W-1:0]              resp_rdata,
	input  wire logic                      mode_wr,
	input  wire logic                      mode_wr_mp,
	output logic                           rom_mapped,
	input  wire logic                      rom_map_select,
	input  wire logic                      hold_req_n,
	input  wire logic                      float_n,
	input  wire logic                      ready,
	output logic [ADDR_W-1:0]              addr_out,
	output logic                           addr_oe,
	input  wire logic [DATA_W-1:0]         data_in,
	output logic [DATA_W-1:0]              data_out,
	output logic                           data_oe,
	output logic                           data_space_sel_n,
	output logic                           program_space_sel_n,
	output logic                           io_space_sel_n,
	output logic                           memory_strobe_n,
	output logic                           io_strobe_n,
	output logic                           rw_n,
	output logic                           ctrl_oe,
	output logic                           bus_grant_ack_n,
	output logic                           grant_oe
);
	ebi_pkg::ebi_state_t state_reg;
	ebi_pkg::ebi_state_t state_next;
	logic [1:0]          space_reg;
	logic                write_reg;
	logic                use_ready_reg;
	logic                mp_reg;
	logic                resp_valid_reg;
	logic                resp_internal_reg;
	logic [DATA_W-1:0]   resp_rdata_reg;
	logic [ADDR_W-1:0]   addr_reg;
	logic [DATA_W-1:0]   wdata_reg;
	logic                cnt_zero;

	function automatic logic is_rom_addr(input logic [ADDR_W-1:0] a);
		is_rom_addr = (a[ADDR_W-1:16] == '0) && (a[15:0] >= ebi_pkg::ROM_BASE);
	endfunction

	wire in_access = (state_reg == ebi_pkg::ST_ACCESS);
	wire in_hold   = (state_reg == ebi_pkg::ST_HOLD);
	wire rom_hit   = (req_space == ebi_pkg::SPACE_PROG) && !mp_reg
		&& is_rom_addr(req_addr);
	wire take      = req_valid && req_ready;
	wire start_ext = take && !rom_hit;
	// Ready counts only after the software waits and only with two or more of them
	wire finish    = in_access && cnt_zero && (!use_ready_reg || ready);

	// Hold is granted only between accesses, never cutting one short
	assign req_ready = (state_reg == ebi_pkg::ST_IDLE) && hold_req_n;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ebi_pkg::ST_IDLE: begin
				if (!hold_req_n) begin
					state_next = ebi_pkg::ST_HOLD;
				end else if (start_ext) begin
					state_next = ebi_pkg::ST_ACCESS;
				end
			end
			ebi_pkg::ST_ACCESS: begin
				if (finish) begin
					state_next = ebi_pkg::ST_IDLE;
				end
			end
			ebi_pkg::ST_HOLD: begin
				if (hold_req_n) begin
					state_next = ebi_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = ebi_pkg::ST_IDLE;
			end
		endcase
	end

	ebi_wait_ctr #(
		.W(ebi_pkg::WAIT_W)
	) u_wait (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.load     (start_ext),
		.load_val (req_waits),
		.cnt_zero (cnt_zero)
	);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg <= ebi_pkg::ST_IDLE;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// Access attributes latched once so address and space hold through the waits
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			space_reg     <= ebi_pkg::SPACE_DATA;
			write_reg     <= 1'b0;
			use_ready_reg <= 1'b0;
			addr_reg      <= '0;
			wdata_reg     <= '0;
		end else if (ce && start_ext) begin
			space_reg     <= req_space;
			write_reg     <= req_write;
			use_ready_reg <= (req_waits >= ebi_pkg::READY_MIN_WAITS);
			addr_reg      <= req_addr;
			wdata_reg     <= req_wdata;
		end
	end

	// Strap caught by the clocked reset; a mode write may change it later
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mp_reg <= rom_map_select;
		end else if (ce && mode_wr) begin
			mp_reg <= mode_wr_mp;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			resp_valid_reg    <= 1'b0;
			resp_internal_reg <= 1'b0;
			resp_rdata_reg    <= '0;
		end else if (ce) begin
			resp_valid_reg    <= finish || (take && rom_hit);
			resp_internal_reg <= take && rom_hit;
			if (finish && !write_reg) begin
				resp_rdata_reg <= data_in;
			end
		end
	end

	assign resp_valid    = resp_valid_reg;
	assign resp_internal = resp_internal_reg;
	assign resp_rdata    = resp_rdata_reg;
	assign rom_mapped    = !mp_reg;

	// Selects and strobes are pure decodes of registered state
	assign program_space_sel_n = !(in_access && space_reg == ebi_pkg::SPACE_PROG);
	assign data_space_sel_n    = !(in_access && space_reg == ebi_pkg::SPACE_DATA);
	assign io_space_sel_n      = !(in_access && space_reg == ebi_pkg::SPACE_IO);
	assign memory_strobe_n     = !(in_access && space_reg != ebi_pkg::SPACE_IO);
	assign io_strobe_n         = !(in_access && space_reg == ebi_pkg::SPACE_IO);
	assign rw_n                = !(in_access && write_reg);
	assign addr_out            = addr_reg;
	assign data_out            = wdata_reg;

	// Enables are high while driving; hold and float control both release the pins
	assign ctrl_oe = float_n && !in_hold;
	assign addr_oe = ctrl_oe;
	assign data_oe = ctrl_oe && in_access && write_reg;
	// Gated by reset so the pin is high even before the first reset edge
	assign bus_grant_ack_n = (in_hold && rst_n) ? 1'b0 : ebi_pkg::GRANT_ACK_RST_N;
	assign grant_oe = float_n;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n || !ce);

	strap_mode_a: assert property (
		$rose(rst_n) |-> rom_mapped == !$past(rom_map_select))
		else $error("reset strap not reflected in ROM mapping");
	mode_write_a: assert property (
		mode_wr |=> rom_mapped == !$past(mode_wr_mp))
		else $error("mode write did not override ROM mapping");
	rom_no_bus_a: assert property (
		take && rom_hit |=> !in_access && resp_valid && resp_internal)
		else $error("internal ROM access reached the external bus");
	rom_out_a: assert property (
		take && mp_reg && req_space == ebi_pkg::SPACE_PROG && is_rom_addr(req_addr)
		|=> in_access)
		else $error("ROM window access stayed internal with the ROM unmapped");
	one_select_a: assert property (
		$countones({data_space_sel_n, program_space_sel_n, io_space_sel_n})
		== (in_access ? 2 : 3))
		else $error("space selects not exactly one low during access");
	addr_stable_a: assert property (
		in_access && $past(in_access) |-> $stable(addr_out)
		&& $stable({data_space_sel_n, program_space_sel_n, io_space_sel_n}))
		else $error("address or select moved inside an access");
	mem_strobe_a: assert property (
		!memory_strobe_n |-> in_access && io_strobe_n)
		else $error("memory strobe low outside a memory access");
	io_strobe_a: assert property (
		!io_strobe_n |-> !io_space_sel_n && memory_strobe_n)
		else $error("I/O strobe low outside an I/O access");
	rw_low_a: assert property (
		!rw_n |-> in_access && write_reg && data_oe == float_n)
		else $error("direction low without a write");
	ready_wait_a: assert property (
		in_access && cnt_zero && use_ready_reg && !ready
		|=> in_access && !memory_strobe_n == (space_reg != ebi_pkg::SPACE_IO))
		else $error("access ended while ready was low");
	ready_ignore_a: assert property (
		in_access && cnt_zero && !use_ready_reg
		|=> state_reg != ebi_pkg::ST_ACCESS ##0 resp_valid)
		else $error("ready not ignored with fewer than two waits");
	no_early_ready_a: assert property (
		in_access && !cnt_zero |=> in_access)
		else $error("access ended before software waits were done");
	float_pins_a: assert property (
		!float_n |-> !ctrl_oe && !addr_oe && !data_oe && !grant_oe)
		else $error("pins driven while float control low");
	hold_float_a: assert property (
		!bus_grant_ack_n |-> !ctrl_oe && !addr_oe && !data_oe)
		else $error("pins driven while hold acknowledged");
	hold_enter_a: assert property (
		state_reg == ebi_pkg::ST_IDLE && !hold_req_n |=> !bus_grant_ack_n)
		else $error("hold request not acknowledged next cycle");
	end_ready_a: assert property (
		in_access && use_ready_reg ##1 !in_access |-> $past(ready))
		else $error("access ended without ready sampled high");
endmodule
`default_nettype wire

/* tb/ebi_mem_model.sv */
// Far-side memory and I/O model with a programmable ready delay
`timescale 1ns/1ps
`default_nettype none
module ebi_mem_model (
	input  wire logic                        sys_clk,
	input  wire logic                        memory_strobe_n,
	input  wire logic                        io_strobe_n,
	input  wire logic                        rw_n,
	input  wire logic [ebi_pkg::ADDR_W-1:0]  addr_out,
	input  wire logic [3:0]                  busy_cycles,
	output logic                             ready,
	output logic [ebi_pkg::DATA_W-1:0]       data_in
);
	logic [3:0]  cnt_reg;
	logic [15:0] last_reg;
	wire logic   active = !memory_strobe_n || !io_strobe_n;
	always_ff @(posedge sys_clk) begin
		cnt_reg <= active ? cnt_reg + 4'h1 : 4'h0;
		last_reg <= data_in;
	end
	// Busy until the commanded span of the strobe is over
	assign ready = active && (cnt_reg >= busy_cycles);
	// Released bus never repeats the last value, so stale captures show up
	assign data_in = (active && rw_n) ? (addr_out[15:0] ^ 16'h5A5A) : ~last_reg;
endmodule
`default_nettype wire

/* tb/ebi_top_tb.sv */
// Self-checking bench for the external bus controller
`timescale 1ns/1ps
`default_nettype none
module ebi_top_tb;
	logic        sys_clk, rst_n, ce, req_valid, req_write, mode_wr, mode_wr_mp;
	logic        rom_map_select, hold_req_n, float_n, ready, req_ready, resp_valid;
	logic        resp_internal, rom_mapped, addr_oe, data_oe, rw_n, ctrl_oe, grant_oe;
	logic        data_space_sel_n, program_space_sel_n, io_space_sel_n;
	logic        memory_strobe_n, io_strobe_n, bus_grant_ack_n;
	logic [1:0]  req_space;
	logic [2:0]  req_waits;
	logic [3:0]  busy_cycles;
	logic [15:0] req_wdata, resp_rdata, data_in, data_out;
	logic [22:0] req_addr, addr_out;
	int          failures = 0;
	int          comparisons = 0;

	ebi_top i_ebi_top (.sys_clk, .rst_n, .ce, .req_valid, .req_ready, .req_space, .req_write,
		.req_addr, .req_wdata, .req_waits, .resp_valid, .resp_internal, .resp_rdata, .mode_wr,
		.mode_wr_mp, .rom_mapped, .rom_map_select, .hold_req_n, .float_n, .ready, .addr_out,
		.addr_oe, .data_in, .data_out, .data_oe, .data_space_sel_n, .program_space_sel_n,
		.io_space_sel_n, .memory_strobe_n, .io_strobe_n, .rw_n, .ctrl_oe, .bus_grant_ack_n,
		.grant_oe);
	ebi_mem_model i_ebi_mem_model (.sys_clk, .memory_strobe_n, .io_strobe_n, .rw_n,
		.addr_out, .busy_cycles, .ready, .data_in);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic do_reset(input logic strap);
		@(negedge sys_clk);
		rst_n = 1'b0;
		rom_map_select = strap;
		repeat (2) @(negedge sys_clk);
		chk("selects", 23'h7,
			{data_space_sel_n, program_space_sel_n, io_space_sel_n});
		chk("strobes", 23'h7, {memory_strobe_n, io_strobe_n, rw_n});
		chk("grant ack", 23'h1, bus_grant_ack_n);
		rst_n = 1'b1;
		// Strap moves after release and must be ignored
		rom_map_select = ~strap;
		@(negedge sys_clk);
		chk("rom mapped", !strap, rom_mapped);
	endtask

	task automatic access(input logic [1:0] sp, input logic wr, input logic [22:0] a,
		input logic [2:0] w, input logic [3:0] busy, input int exp_n);
		int n;
		n = 0;
		busy_cycles = busy;
		req_space = sp;
		req_write = wr;
		req_addr = a;
		req_wdata = ~a[15:0];
		req_waits = w;
		req_valid = 1'b1;
		#1;
		chk("req ready", 23'h1, req_ready);
		@(negedge sys_clk);
		req_valid = 1'b0;
		while (resp_valid !== 1'b1 && n < 40) begin
			chk("select", sp == 0 ? 23'h5 : sp == 1 ? 23'h3 : 23'h6,
				{data_space_sel_n, program_space_sel_n, io_space_sel_n});
			chk("strobe", sp == 2 ? 23'h2 : 23'h1, {memory_strobe_n, io_strobe_n});
			chk("direction", !wr, rw_n);
			chk("data oe", wr, data_oe);
			chk("address", a, addr_out);
			if (wr)
				chk("write data", {7'h0, ~a[15:0]}, data_out);
			n++;
			@(negedge sys_clk);
		end
		chk("cycles", 23'(exp_n), 23'(n));
		chk("internal", exp_n == 0, resp_internal);
		chk("idle", 23'h3F, {data_space_sel_n, program_space_sel_n, io_space_sel_n,
			memory_strobe_n, io_strobe_n, rw_n});
		if (!wr && exp_n > 0)
			chk("read data", a[15:0] ^ 16'h5A5A, resp_rdata);
	endtask

	task automatic mode_write(input logic mp);
		mode_wr = 1'b1;
		mode_wr_mp = mp;
		@(negedge sys_clk);
		mode_wr = 1'b0;
		chk("mode", !mp, rom_mapped);
	endtask

	task automatic hold_float;
		hold_req_n = 1'b0;
		@(negedge sys_clk);
		chk("grant ack", 23'h0, bus_grant_ack_n);
		chk("hold oe", 23'h0, {ctrl_oe, addr_oe, data_oe, req_ready});
		hold_req_n = 1'b1;
		@(negedge sys_clk);
		chk("released", 23'h7, {bus_grant_ack_n, ctrl_oe, addr_oe});
		float_n = 1'b0;
		#1;
		chk("float oe", 23'h0, {ctrl_oe, addr_oe, grant_oe});
		@(negedge sys_clk);
		float_n = 1'b1;
	endtask

	// Hold asked for mid-access must wait until the access has ended
	task automatic hold_mid;
		busy_cycles = 4'h0;
		req_space = 2'h1;
		req_write = 1'b0;
		req_addr = 23'h00_0321;
		req_waits = 3'h3;
		req_valid = 1'b1;
		@(negedge sys_clk);
		req_valid = 1'b0;
		hold_req_n = 1'b0;
		repeat (4) begin
			chk("ack in access", 23'h1, bus_grant_ack_n);
			chk("select in access", 23'h3,
				{data_space_sel_n, program_space_sel_n, io_space_sel_n});
			@(negedge sys_clk);
		end
		chk("end before hold", 23'h1, resp_valid);
		chk("read before hold", 23'h0321 ^ 23'h5A5A, resp_rdata);
		@(negedge sys_clk);
		chk("grant after access", 23'h0, bus_grant_ack_n);
		hold_req_n = 1'b1;
		@(negedge sys_clk);
		chk("grant released", 23'h1, bus_grant_ack_n);
	endtask

	// Whole run is about fifty cycles; a hang far beyond that is a failure
	initial begin
		#20000;
		failures++;
		conclude;
	end

	initial begin
		{rst_n, req_valid, req_write, mode_wr, mode_wr_mp, rom_map_select} = '0;
		{ce, hold_req_n, float_n} = 3'h7;
		{req_space, req_waits, busy_cycles, req_wdata, req_addr} = '0;
		do_reset(1'b0);
		access(2'h0, 1'b0, 23'h00_C123, 3'h0, 4'h0, 0);
		access(2'h1, 1'b0, 23'h00_1234, 3'h0, 4'h0, 1);
		access(2'h1, 1'b1, 23'h00_2345, 3'h1, 4'h5, 2);
		access(2'h2, 1'b0, 23'h00_0777, 3'h2, 4'h2, 3);
		access(2'h0, 1'b0, 23'h01_0456, 3'h3, 4'h6, 7);
		access(2'h2, 1'b1, 23'h00_0ABC, 3'h7, 4'h9, 10);
		mode_write(1'b1);
		access(2'h0, 1'b0, 23'h00_C123, 3'h0, 4'h0, 1);
		do_reset(1'b1);
		access(2'h0, 1'b1, 23'h00_FFFF, 3'h2, 4'h0, 3);
		hold_float;
		hold_mid;
		conclude;
	end
endmodule
`default_nettype wire
